// File: asrc_pkg.sv
// package for the auto sleep rate controller: register map, field layouts,
// reset values, timing constants, rate and oversampling decode functions.
// assumes a single 250 MHz core clock and an 8-bit register port.
package asrc_pkg;

  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ADDR_INACTIVITY_COUNT  = 8'h29;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL_ONE = 8'h2a;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL_TWO = 8'h2b;

  localparam logic [7:0] RST_INACTIVITY_COUNT = 8'h00;
  localparam logic [7:0] RST_CONTROL_ONE      = 8'h00;
  localparam logic [7:0] RST_CONTROL_TWO      = 8'h00;

  // field positions inside the control registers
  localparam int unsigned POS_ACTIVE        = 0;
  localparam int unsigned POS_SW_RESET      = 6;
  localparam int unsigned POS_CTRL2_RSVD    = 5;

  // ****************************************************************
  // codes
  // ****************************************************************
  localparam logic [2:0] RATE_800HZ  = 3'h0;
  localparam logic [2:0] RATE_50HZ   = 3'h4;
  localparam logic [2:0] RATE_1P56HZ = 3'h7;

  localparam logic [1:0] OS_NORMAL = 2'h0;
  localparam logic [1:0] OS_LNLP   = 2'h1;
  localparam logic [1:0] OS_HIRES  = 2'h2;
  localparam logic [1:0] OS_LOWPWR = 2'h3;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS     = 4;
  localparam int unsigned BASE_PERIOD_NS    = 1250000;  // 1.25 ms, the 800 Hz period
  localparam int unsigned BASE_TICK_CYCLES  = BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned STEP_FAST_MS      = 320;
  localparam int unsigned STEP_SLOW_MS      = 640;
  localparam int unsigned STEP_FAST_TICKS   = (STEP_FAST_MS * 1000000) / BASE_PERIOD_NS;
  localparam int unsigned STEP_SLOW_TICKS   = (STEP_SLOW_MS * 1000000) / BASE_PERIOD_NS;
  localparam int unsigned BOOT_CYCLES       = 16;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef struct packed {
    logic [1:0] sleep_rate_sel;
    logic [2:0] data_rate_sel;
    logic       low_noise_sel;
    logic       fast_read_sel;
    logic       active;
  } asrc_ctrl_one_t;

  typedef struct packed {
    logic       self_test_en;
    logic       sw_reset;
    logic       rsvd;
    logic [1:0] sleep_oversample_sel;
    logic       auto_sleep_en;
    logic [1:0] wake_oversample_sel;
  } asrc_ctrl_two_t;

  typedef struct packed {
    logic transient_event;
    logic orientation_event;
    logic pulse_event;
    logic freefall_motion_event;
    logic data_ready_event;
  } asrc_events_t;

  typedef struct packed {
    logic sleep_wake;
    logic transient;
    logic orientation;
    logic pulse;
    logic freefall_motion;
    logic data_ready;
  } asrc_int_en_t;

  typedef struct packed {
    logic transient;
    logic orientation;
    logic pulse;
    logic freefall_motion;
  } asrc_wake_cfg_t;

  typedef enum logic [1:0] {
    ASRC_STANDBY = 2'b00,
    ASRC_WAKE    = 2'b01,
    ASRC_SLEEP   = 2'b10
  } asrc_state_t;

  // ****************************************************************
  // functions
  // ****************************************************************
  // sample period in 1.25 ms base ticks for a data rate code
  function automatic logic [9:0] rate_div_ticks(input logic [2:0] code);
    case (code)
      3'h0:    rate_div_ticks = 10'h001;
      3'h1:    rate_div_ticks = 10'h002;
      3'h2:    rate_div_ticks = 10'h004;
      3'h3:    rate_div_ticks = 10'h008;
      3'h4:    rate_div_ticks = 10'h010;
      3'h5:    rate_div_ticks = 10'h040;
      3'h6:    rate_div_ticks = 10'h080;
      default: rate_div_ticks = 10'h200;
    endcase
  endfunction

  // sleep rate field mapped onto the data rate code space
  function automatic logic [2:0] sleep_to_rate(input logic [1:0] sel);
    sleep_to_rate = RATE_50HZ + {1'b0, sel};
  endfunction

  // log2 of the oversampling ratio for a scheme at a rate
  function automatic logic [3:0] os_log2(input logic [1:0] scheme, input logic [2:0] code);
    os_log2 = 4'h1;
    if (code != RATE_800HZ) begin
      case (scheme)
        OS_NORMAL: begin
          case (code)
            3'h5:    os_log2 = 4'h4;
            3'h6:    os_log2 = 4'h5;
            3'h7:    os_log2 = 4'h7;
            default: os_log2 = 4'h2;
          endcase
        end
        OS_LNLP: begin
          case (code)
            3'h6:    os_log2 = 4'h3;
            3'h7:    os_log2 = 4'h5;
            default: os_log2 = 4'h2;
          endcase
        end
        OS_HIRES: begin
          case (code)
            3'h5:    os_log2 = 4'h7;
            3'h6:    os_log2 = 4'h8;
            3'h7:    os_log2 = 4'ha;
            default: os_log2 = 4'h1 + {1'b0, code};
          endcase
        end
        default: begin
          case (code)
            3'h6:    os_log2 = 4'h2;
            3'h7:    os_log2 = 4'h4;
            default: os_log2 = 4'h1;
          endcase
        end
      endcase
    end
  endfunction

endpackage

// File: asrc_tick_gen.sv
// sample clock generator: a 1.25 ms base tick and a sample tick at the
// selected rate code. assumes run is held low in standby.
`timescale 1ns/1ps
`default_nettype none
module asrc_tick_gen #(
  parameter int unsigned BASE_CYCLES = asrc_pkg::BASE_TICK_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic [2:0] rate_code,
  output logic            base_tick,
  output logic            sample_tick
);

  localparam int unsigned CW = (BASE_CYCLES > 2) ? $clog2(BASE_CYCLES) : 1;
  localparam logic [CW-1:0] BASE_LAST = CW'(BASE_CYCLES - 1);

  logic [CW-1:0] base_cnt_q;
  logic [9:0]    sub_cnt_q;
  logic          base_hit;
  logic [9:0]    sub_last;

  assign base_hit = run && (base_cnt_q == BASE_LAST);
  assign sub_last = asrc_pkg::rate_div_ticks(rate_code) - 10'h001;

  // ****************************************************************
  // base divider
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      base_cnt_q <= '0;
    end else if (!run || base_hit) begin
      base_cnt_q <= '0;
    end else begin
      base_cnt_q <= base_cnt_q + CW'(1);
    end
  end

  // ****************************************************************
  // rate divider
  // ****************************************************************
  // a rate change restarts cleanly because the compare is >=
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sub_cnt_q <= 10'h000;
    end else if (!run) begin
      sub_cnt_q <= 10'h000;
    end else if (base_hit) begin
      sub_cnt_q <= (sub_cnt_q >= sub_last) ? 10'h000 : sub_cnt_q + 10'h001;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      base_tick   <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      base_tick   <= base_hit;
      sample_tick <= base_hit && (sub_cnt_q >= sub_last);
    end
  end

endmodule
`default_nettype wire

// File: asrc_auto_sleep_rate_control.sv
// power mode and sample rate controller with inactivity driven auto sleep.
// assumes the serial bus front end presents byte wide register accesses
// on reg_wr / reg_rd and that event inputs are one-cycle pulses.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - inactivity_count sets the minimum quiet time before dropping to the sleep rate
// - each count step is 320 ms, or 640 ms when the active rate is 1.56 Hz
// - enabled transient, orientation, pulse, freefall/motion events restart timer and may wake
// - data ready and sleep/wake events neither restart the timer nor wake
// - only enabled functions also chosen in wake_config can wake the device
// - enabled detectors keep running while asleep, clocked at the sleep rate
// - with auto_sleep_en clear the device only moves between standby and wake
// - wake to sleep and sleep to wake transitions raise an event when enabled
// - sleep_rate_sel picks 50, 12.5, 6.25 or 1.56 Hz, reset value 00
// - in auto sleep the output and block rates follow the sleep rate
// - data_rate_sel picks 800 Hz down to 1.56 Hz in eight steps
// - active bit: 0 standby (reset), 1 active
// - low noise mode limits range to 4g so higher thresholds never trip
// - fast read makes auto increment skip the low data bytes
// - self test bit shifts all three axis outputs while set
// - writing 1 to software reset reloads defaults and resets the serial bus
// - software reset bit clears when boot ends and always reads 0
// - separate wake and sleep oversampling fields select one of four schemes
// - oversampling ratio depends on both the scheme and the rate
// - auto_sleep_en permits sleep when set, reset value 0
// - wake_config holds one wake permit bit per function
module asrc_auto_sleep_rate_control #(
  parameter int unsigned BASE_CYCLES = asrc_pkg::BASE_TICK_CYCLES,
  parameter int unsigned BOOT_LEN    = asrc_pkg::BOOT_CYCLES
) (
  input  wire logic                     core_clk,
  input  wire logic                     rst,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  input  wire logic [7:0]               reg_addr,
  input  wire logic [7:0]               reg_wdata,
  output logic      [7:0]               reg_rdata,
  input  wire asrc_pkg::asrc_events_t   events,
  input  wire asrc_pkg::asrc_int_en_t   int_en,
  input  wire asrc_pkg::asrc_wake_cfg_t wake_cfg,
  output asrc_pkg::asrc_state_t         power_state,
  output logic      [2:0]               eff_rate_code,
  output logic      [1:0]               eff_oversample_sel,
  output logic      [10:0]              os_ratio,
  output logic                          sample_tick,
  output logic                          sleep_wake_event,
  output logic                          low_noise_sel,
  output logic                          range_limit_4g,
  output logic                          fast_read_sel,
  output logic                          self_test_en,
  output logic                          serial_if_reset,
  output logic                          boot_busy
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  localparam int unsigned BW = (BOOT_LEN > 2) ? $clog2(BOOT_LEN) : 1;
  localparam logic [BW-1:0] BOOT_LAST = BW'(BOOT_LEN - 1);
  localparam logic [9:0] STEP_FAST = 10'(asrc_pkg::STEP_FAST_TICKS - 1);
  localparam logic [9:0] STEP_SLOW = 10'(asrc_pkg::STEP_SLOW_TICKS - 1);

  logic [7:0]              inactivity_count_q;
  asrc_pkg::asrc_ctrl_one_t ctrl_one_q;
  asrc_pkg::asrc_ctrl_two_t ctrl_two_q;
  asrc_pkg::asrc_state_t   state_q;
  asrc_pkg::asrc_state_t   state_d;

  logic       boot_q;
  logic [BW-1:0] boot_cnt_q;
  logic       sw_reset_req;
  logic       wr_ok;

  logic [9:0] step_tick_q;
  logic [7:0] steps_q;
  logic       quiet_expired;
  logic       keep_awake;
  logic       wake_hit;
  logic [9:0] step_last;
  logic       base_tick;
  logic       tick_sample;
  logic [2:0] rate_now;
  logic [1:0] os_now;

  // ****************************************************************
  // software reset and boot
  // ****************************************************************
  assign wr_ok = reg_wr && !boot_q;
  assign sw_reset_req = wr_ok && (reg_addr == asrc_pkg::ADDR_SYSTEM_CONTROL_TWO)
                        && reg_wdata[asrc_pkg::POS_SW_RESET];

  // bus writes during boot are dropped, the front end is being reset anyway
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      boot_q     <= 1'b0;
      boot_cnt_q <= '0;
    end else if (sw_reset_req) begin
      boot_q     <= 1'b1;
      boot_cnt_q <= '0;
    end else if (boot_q) begin
      if (boot_cnt_q == BOOT_LAST) begin
        boot_q <= 1'b0;
      end
      boot_cnt_q <= boot_cnt_q + BW'(1);
    end
  end

  assign boot_busy       = boot_q;
  assign serial_if_reset = boot_q;

  // ****************************************************************
  // register file
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      inactivity_count_q <= asrc_pkg::RST_INACTIVITY_COUNT;
    end else if (sw_reset_req) begin
      inactivity_count_q <= asrc_pkg::RST_INACTIVITY_COUNT;
    end else if (wr_ok && reg_addr == asrc_pkg::ADDR_INACTIVITY_COUNT) begin
      inactivity_count_q <= reg_wdata;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_one_q <= asrc_pkg::RST_CONTROL_ONE;
    end else if (sw_reset_req) begin
      ctrl_one_q <= asrc_pkg::RST_CONTROL_ONE;
    end else if (wr_ok && reg_addr == asrc_pkg::ADDR_SYSTEM_CONTROL_ONE) begin
      if (ctrl_one_q.active) begin
        // fields other than active are frozen while running
        ctrl_one_q.active <= reg_wdata[asrc_pkg::POS_ACTIVE];
      end else begin
        ctrl_one_q <= reg_wdata;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_two_q <= asrc_pkg::RST_CONTROL_TWO;
    end else if (sw_reset_req) begin
      ctrl_two_q <= asrc_pkg::RST_CONTROL_TWO;
    end else if (wr_ok && reg_addr == asrc_pkg::ADDR_SYSTEM_CONTROL_TWO) begin
      ctrl_two_q          <= reg_wdata;
      ctrl_two_q.sw_reset <= 1'b0;
      ctrl_two_q.rsvd     <= 1'b0;
    end
  end

  // registered read data, valid the cycle after reg_rd
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        asrc_pkg::ADDR_INACTIVITY_COUNT:   reg_rdata <= inactivity_count_q;
        asrc_pkg::ADDR_SYSTEM_CONTROL_ONE: reg_rdata <= ctrl_one_q;
        asrc_pkg::ADDR_SYSTEM_CONTROL_TWO: begin
          reg_rdata                         <= ctrl_two_q;
          reg_rdata[asrc_pkg::POS_SW_RESET] <= 1'b0;
        end
        default:                           reg_rdata <= 8'h00;
      endcase
    end
  end

  // ****************************************************************
  // event qualification
  // ****************************************************************
  // data ready and the sleep/wake event itself are left out on purpose
  assign keep_awake = (events.transient_event       && int_en.transient)
                   || (events.orientation_event     && int_en.orientation)
                   || (events.pulse_event           && int_en.pulse)
                   || (events.freefall_motion_event && int_en.freefall_motion);

  assign wake_hit = (events.transient_event       && int_en.transient       && wake_cfg.transient)
                 || (events.orientation_event     && int_en.orientation     && wake_cfg.orientation)
                 || (events.pulse_event           && int_en.pulse           && wake_cfg.pulse)
                 || (events.freefall_motion_event && int_en.freefall_motion
                     && wake_cfg.freefall_motion);

  // ****************************************************************
  // inactivity timer
  // ****************************************************************
  // step length follows the active rate, not the sleep rate
  assign step_last = (ctrl_one_q.data_rate_sel == asrc_pkg::RATE_1P56HZ)
                     ? STEP_SLOW : STEP_FAST;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      step_tick_q <= 10'h000;
      steps_q     <= 8'h00;
    end else if (state_q != asrc_pkg::ASRC_WAKE || keep_awake || boot_q) begin
      step_tick_q <= 10'h000;
      steps_q     <= 8'h00;
    end else if (base_tick) begin
      if (step_tick_q >= step_last) begin
        step_tick_q <= 10'h000;
        if (steps_q != 8'hff) begin
          steps_q <= steps_q + 8'h01;
        end
      end else begin
        step_tick_q <= step_tick_q + 10'h001;
      end
    end
  end

  // a count of zero lets sleep follow the first quiet cycle
  assign quiet_expired = (steps_q >= inactivity_count_q) && !keep_awake;

  // ****************************************************************
  // power state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      asrc_pkg::ASRC_STANDBY: begin
        if (ctrl_one_q.active) begin
          state_d = asrc_pkg::ASRC_WAKE;
        end
      end
      asrc_pkg::ASRC_WAKE: begin
        if (!ctrl_one_q.active) begin
          state_d = asrc_pkg::ASRC_STANDBY;
        end else if (ctrl_two_q.auto_sleep_en && quiet_expired) begin
          state_d = asrc_pkg::ASRC_SLEEP;
        end
      end
      asrc_pkg::ASRC_SLEEP: begin
        if (!ctrl_one_q.active) begin
          state_d = asrc_pkg::ASRC_STANDBY;
        end else if (wake_hit || !ctrl_two_q.auto_sleep_en) begin
          state_d = asrc_pkg::ASRC_WAKE;
        end
      end
      default: state_d = asrc_pkg::ASRC_STANDBY;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= asrc_pkg::ASRC_STANDBY;
    end else if (sw_reset_req || boot_q) begin
      state_q <= asrc_pkg::ASRC_STANDBY;
    end else begin
      state_q <= state_d;
    end
  end

  // transition pulse only between wake and sleep, not to or from standby
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sleep_wake_event <= 1'b0;
    end else begin
      sleep_wake_event <= int_en.sleep_wake && !sw_reset_req && !boot_q
                          && (((state_q == asrc_pkg::ASRC_WAKE)
                               && (state_d == asrc_pkg::ASRC_SLEEP))
                           || ((state_q == asrc_pkg::ASRC_SLEEP)
                               && (state_d == asrc_pkg::ASRC_WAKE)));
    end
  end

  // ****************************************************************
  // effective rate and oversampling
  // ****************************************************************
  assign rate_now = (state_q == asrc_pkg::ASRC_SLEEP)
                    ? asrc_pkg::sleep_to_rate(ctrl_one_q.sleep_rate_sel)
                    : ctrl_one_q.data_rate_sel;
  assign os_now   = (state_q == asrc_pkg::ASRC_SLEEP)
                    ? ctrl_two_q.sleep_oversample_sel
                    : ctrl_two_q.wake_oversample_sel;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      eff_rate_code      <= asrc_pkg::RATE_800HZ;
      eff_oversample_sel <= asrc_pkg::OS_NORMAL;
      os_ratio           <= 11'h002;
    end else begin
      eff_rate_code      <= rate_now;
      eff_oversample_sel <= os_now;
      os_ratio           <= 11'h001 << asrc_pkg::os_log2(os_now, rate_now);
    end
  end

  // one tick source serves both wake and sleep, so detectors stop only in standby
  asrc_tick_gen #(
    .BASE_CYCLES (BASE_CYCLES)
  ) u_tick (
    .core_clk    (core_clk),
    .rst         (rst),
    .run         (state_q != asrc_pkg::ASRC_STANDBY),
    .rate_code   (rate_now),
    .base_tick   (base_tick),
    .sample_tick (tick_sample)
  );

  assign sample_tick = tick_sample;

  // ****************************************************************
  // mode outputs
  // ****************************************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      low_noise_sel  <= 1'b0;
      range_limit_4g <= 1'b0;
      fast_read_sel  <= 1'b0;
      self_test_en   <= 1'b0;
    end else begin
      low_noise_sel  <= ctrl_one_q.low_noise_sel;
      range_limit_4g <= ctrl_one_q.low_noise_sel;
      fast_read_sel  <= ctrl_one_q.fast_read_sel;
      self_test_en   <= ctrl_two_q.self_test_en;
    end
  end

  assign power_state = state_q;

endmodule
`default_nettype wire

// File: asrc_host_model.sv
// host model: byte register master for the controller
// assumes read data is valid the cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module asrc_host_model (
  input  wire logic       core_clk,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire

// File: asrc_auto_sleep_rate_control_assertions.sv
// checker on the controller top ports
// assumes one clock and rst asynchronous active high
`timescale 1ns/1ps
`default_nettype none
module asrc_chk (
  input wire logic                     core_clk,
  input wire logic                     rst,
  input wire asrc_pkg::asrc_events_t   events,
  input wire asrc_pkg::asrc_int_en_t   int_en,
  input wire asrc_pkg::asrc_wake_cfg_t wake_cfg,
  input wire asrc_pkg::asrc_state_t    power_state,
  input wire logic [2:0]               eff_rate_code,
  input wire logic [10:0]              os_ratio,
  input wire logic                     sample_tick,
  input wire logic                     sleep_wake_event,
  input wire logic                     low_noise_sel,
  input wire logic                     range_limit_4g,
  input wire logic                     self_test_en,
  input wire logic                     boot_busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sleep_evt_a: assert property (
    power_state == 2'h2 && $past(power_state) == 2'h1 && int_en.sleep_wake |-> sleep_wake_event)
    else $error("no event on sleep entry");
  sleep_rate_a: assert property (
    power_state == 2'h2 [*2] |-> eff_rate_code[2]) else $error("rate not sleep rate");
  ev_wake_a: assert property (
    power_state == 2'h2 && |(events[4:1] & int_en[4:1] & wake_cfg) |=> power_state == 2'h1)
    else $error("wake event ignored");
  drdy_sleep_a: assert property (
    power_state == 2'h2 && events == 5'h01 |=> power_state == 2'h2) else $error("data ready woke");
  os_fast_a: assert property (
    (power_state == 2'h1 && eff_rate_code == 3'h0) [*3] |-> os_ratio == 11'h002)
    else $error("ratio at 800 Hz");
  idle_tick_a: assert property (
    power_state == 2'h0 [*3] |-> !sample_tick) else $error("tick in standby");
  range_lim_a: assert property (
    range_limit_4g == low_noise_sel) else $error("range limit mismatch");
  boot_clr_a: assert property (
    boot_busy [*2] |-> !self_test_en && !low_noise_sel && power_state == 2'h0)
    else $error("defaults not loaded");
endmodule
bind asrc_auto_sleep_rate_control asrc_chk chk (.*);
`default_nettype wire

// File: asrc_auto_sleep_rate_control_tb.sv
// testbench for the auto sleep rate controller
// assumes the host model on the register port; short base tick for speed
`timescale 1ns/1ps
`default_nettype none
module asrc_auto_sleep_rate_control_tb;
  logic                     core_clk, rst, reg_wr, reg_rd, sample_tick, sleep_wake_event;
  logic                     low_noise_sel, range_limit_4g, fast_read_sel, self_test_en;
  logic                     serial_if_reset, boot_busy;
  logic [7:0]               reg_addr, reg_wdata, reg_rdata, rv;
  logic [2:0]               eff_rate_code;
  logic [1:0]               eff_oversample_sel;
  logic [10:0]              os_ratio;
  asrc_pkg::asrc_events_t   events;
  asrc_pkg::asrc_int_en_t   int_en;
  asrc_pkg::asrc_wake_cfg_t wake_cfg;
  asrc_pkg::asrc_state_t    power_state;
  int                       err_total, cmp_count, n, swe, stk;
  logic [23:0]              tbl [4] = '{24'h29a5a5, 24'h2afefe, 24'h2bbf9f, 24'h3f5500};
  asrc_host_model host (.*);
  asrc_auto_sleep_rate_control #(.BASE_CYCLES(4), .BOOT_LEN(4)) uut (.*);
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (sleep_wake_event === 1'b1) swe++;
  always @(posedge core_clk) if (sample_tick === 1'b1) stk++;
  task automatic chk(input logic ok, input string m);
    cmp_count++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic ev(input logic [4:0] e);
    @(posedge core_clk);
    events <= e;
    @(posedge core_clk);
    events <= 5'h00;
  endtask
  // data ready pulses while waiting: they must not hold off sleep
  task automatic wait_st(input logic [1:0] s);
    n = 0;
    while (power_state !== s && n < 3000) begin
      @(posedge core_clk);
      events <= {4'h0, n[0]};
      n++;
      #1;
    end
    events <= 5'h00;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    events = '0;
    int_en = 6'h3f;
    wake_cfg = 4'h1;
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      host.rd(8'h29 + i[7:0], rv);
      chk(rv === 8'h00, "reset value");
    end
    foreach (tbl[i]) begin
      host.wr(tbl[i][23:16], tbl[i][15:8]);
      host.rd(tbl[i][23:16], rv);
      chk(rv === tbl[i][7:0], "readback");
    end
    chk({low_noise_sel, range_limit_4g, fast_read_sel, self_test_en} === 4'hf, "bits");
    host.wr(8'h2b, 8'h02);
    host.wr(8'h2a, 8'h38);
    host.wr(8'h2a, 8'h39);
    wait_st(2'h1);
    repeat (4) @(posedge core_clk);
    chk(os_ratio === 11'h400 && eff_rate_code === 3'h7, "hires");
    chk(self_test_en === 1'b0, "self test");
    host.wr(8'h2a, 8'h38);
    host.wr(8'h29, 8'h01);
    host.wr(8'h2b, 8'h0c);
    host.wr(8'h2a, 8'hc0);
    host.wr(8'h2a, 8'hc1);
    swe = 0;
    stk = 0;
    wait_st(2'h2);
    chk(stk > 200, "no sample ticks in wake");
    chk(n > 800 && n < 3000, "sleep time");
    repeat (3) @(posedge core_clk);
    chk(eff_rate_code === 3'h7 && eff_oversample_sel === 2'h1 && swe == 1, "sleep");
    ev(5'h01);
    ev(5'h10);
    repeat (2) @(posedge core_clk);
    chk(power_state === 2'h2, "no wake");
    ev(5'h02);
    repeat (3) @(posedge core_clk);
    chk(power_state === 2'h1 && eff_rate_code === 3'h0 && swe == 2, "wake");
    host.wr(8'h2b, 8'h08);
    wait_st(2'h2);
    chk(n == 3000 && power_state === 2'h1, "stay awake");
    host.wr(8'h2b, 8'h40);
    #1 chk(boot_busy === 1'b1 && serial_if_reset === 1'b1 && power_state === 2'h0, "soft reset");
    repeat (8) @(posedge core_clk);
    host.rd(8'h2a, rv);
    chk(rv === 8'h00, "defaults");
    conclude();
  end
  initial begin
    #100000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
